// [wdt_pkg.sv]
// Constants and carrier types for the watchdog with sleep control.
// Assumes one 25 MHz clock and a single AHB-Lite slave port.
//
// Behaviour
// - Watchdog counts low-frequency oscillator ticks; oscillator enabled whenever watchdog runs.
// - A 4 ms base tick feeds a postscaler; configuration selects the time-out tap.
// - Selectable periods run from 4 ms up to about 4194 seconds.
// - Clear, sleep, oscillator frequency change or clock failure clear divider and postscaler.
// - Two configuration bits choose always on, software, or awake-only; the off code also leaves control bit 0 in charge.
// - In software operation control bit 0 starts and stops the watchdog.
// - Software enable is ignored when configuration already enables the watchdog.
// - Control bit 7 puts the regulator into low power during sleep.
// - Bit 4 with regulator enabled and retention low selects ultra-low-power sleep.
// - Sleep ultra-low select works only while the retention configuration bit is low.
// - Bit 2 enables ultra-low wake-up; bit 5 reads its comparator when enabled.
// - Bit 1 enables the wake-up current sink, effective only with bit 2 set.
// - Control bits 6 and 3 read zero and ignore writes.
// - On regulator-bypassed variants the regulator sleep low-power bit has no effect.
// - Fail-safe monitor keeps the oscillator on; watchdog divider stays separate.
package wdt_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned BASE_PERIOD_MS = 4;
  localparam int unsigned BASE_CYCLES    = BASE_PERIOD_MS * (CLK_HZ / MS_PER_S);

  // Postscaler: 2**20 base periods give the longest time-out
  localparam int unsigned POST_W     = 20;
  localparam int unsigned SEL_W      = 5;
  localparam int unsigned FREQ_SEL_W = 3;

  // Register map, byte addresses within the slave window
  localparam int unsigned    ADDR_W          = 12;
  localparam int unsigned    REG_W           = 8;
  localparam logic [11:0]    CTRL_OFS        = 12'h000;
  localparam logic [11:0]    RESET_CAUSE_OFS = 12'h004;

  // Watchdog control register fields
  localparam int unsigned REG_LOWPOWER_BIT = 7;
  localparam int unsigned ULP_LEVEL_BIT    = 5;
  localparam int unsigned SLEEP_ULTRA_BIT  = 4;
  localparam int unsigned ULP_ENABLE_BIT   = 2;
  localparam int unsigned ULP_SINK_BIT     = 1;
  localparam int unsigned SOFT_ON_BIT      = 0;

  // Reset cause register fields, write one to clear
  localparam int unsigned TIMEOUT_FLAG_BIT   = 3;
  localparam int unsigned POWERDOWN_FLAG_BIT = 2;

  // Watchdog mode configuration codes
  localparam logic [1:0] MODE_OFF        = 2'h0;
  localparam logic [1:0] MODE_SOFT       = 2'h1;
  localparam logic [1:0] MODE_AWAKE_ONLY = 2'h2;
  localparam logic [1:0] MODE_ALWAYS     = 2'h3;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Configuration straps
  typedef struct packed {
    logic [1:0]       watchdog_mode_cfg;
    logic [SEL_W-1:0] post_sel;
    logic             regulator_retention_cfg_n;
    logic             regulator_bypass;
    logic             fail_safe_clock_monitor;
  } cfg_t;

  // Register write from the bus port
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  data;
  } reg_wr_t;

  // Power controls toward regulator and wake-up module
  typedef struct packed {
    logic reg_lowpower;
    logic reg_ultralow;
    logic ultralow_wake_enable;
    logic ultralow_wake_sink_enable;
  } pwr_ctrl_t;

endpackage

// [base_tick_gen.sv]
// Base tick divider: one-cycle pulse every CYCLES clocks while running.
// Assumes run_i and clear_i synchronous to clk_i; CYCLES at least 2.
`timescale 1ns/1ps
module base_tick_gen #(
  parameter int unsigned CYCLES = wdt_pkg::BASE_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic run_i,
  input  wire logic clear_i,
  // Tick
  output logic      tick_o
);
  localparam int unsigned   CW   = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } tick_st_t;

  tick_st_t s_q, s_d;

  // Own divider, independent of any clock monitor divider
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (clear_i || !run_i) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == LAST) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule // base_tick_gen

// [ahb_reg_port.sv]
// AHB-Lite slave front end for byte-wide registers in word slots.
// Assumes single word transfers; zero wait states, always OKAY.
`timescale 1ns/1ps
module ahb_reg_port #(
  parameter int unsigned AW = wdt_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // AHB-Lite slave
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic [31:0]                hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  // Core side
  output wdt_pkg::reg_wr_t           wr_o,
  output logic [AW-1:0]              rd_addr_o,
  input  wire logic [wdt_pkg::REG_W-1:0] rd_data_i
);
  typedef struct packed {
    logic          wr_pend;
    logic [AW-1:0] wr_addr;
    logic [31:0]   rdata;
  } port_st_t;

  port_st_t s_q, s_d;
  logic     take;

  // Address phase accepted; narrow transfers are ignored
  assign take = hsel_i && hready_i && (htrans_i == wdt_pkg::HTRANS_NONSEQ)
                && (hsize_i == wdt_pkg::HSIZE_WORD);
  assign rd_addr_o = haddr_i[AW-1:0];

  // Read data captured at the address phase so it comes from a flop
  always_comb begin
    s_d         = s_q;
    s_d.wr_pend = take && hwrite_i;
    if (take) begin
      s_d.wr_addr = haddr_i[AW-1:0];
    end
    if (take && !hwrite_i) begin
      s_d.rdata = {{(32 - wdt_pkg::REG_W){1'b0}}, rd_data_i};
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Write lands at the end of the data phase
  assign wr_o.valid  = s_q.wr_pend;
  assign wr_o.addr   = s_q.wr_addr;
  assign wr_o.data   = hwdata_i[wdt_pkg::REG_W-1:0];
  assign hrdata_o    = s_q.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

endmodule // ahb_reg_port

// [watchdog_with_sleep_control.sv]
// Watchdog timer with the shared watchdog control register, sleep state
// tracking, regulator sleep selects and ultra-low-power wake-up controls.
// Assumes every input is synchronous to clk_i and one AHB-Lite master.
`timescale 1ns/1ps
module watchdog_with_sleep_control #(
  parameter int unsigned BASE_CYCLES = wdt_pkg::BASE_CYCLES,
  parameter int unsigned POST_W      = wdt_pkg::POST_W
) (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  // AHB-Lite slave
  input  wire logic                              hsel_i,
  input  wire logic [31:0]                       haddr_i,
  input  wire logic [1:0]                        htrans_i,
  input  wire logic                              hwrite_i,
  input  wire logic [2:0]                        hsize_i,
  input  wire logic [31:0]                       hwdata_i,
  input  wire logic                              hready_i,
  output logic [31:0]                            hrdata_o,
  output logic                                   hreadyout_o,
  output logic                                   hresp_o,
  // Configuration straps
  input  wire wdt_pkg::cfg_t                     cfg_i,
  input  wire logic [wdt_pkg::FREQ_SEL_W-1:0]    int_osc_freq_select_i,
  // Core events, one-cycle pulses
  input  wire logic                              clear_watchdog_instr_i,
  input  wire logic                              sleep_instr_i,
  input  wire logic                              wake_event_i,
  input  wire logic                              clock_fail_i,
  // Wake-up comparator
  input  wire logic                              ultralow_wake_level_i,
  // Oscillator and watchdog status
  output logic                                   low_freq_internal_osc_en_o,
  output logic                                   watchdog_running_o,
  output logic                                   watchdog_reset_o,
  output logic                                   watchdog_wake_o,
  output logic                                   asleep_o,
  // Power controls
  output wdt_pkg::pwr_ctrl_t                     pwr_o
);

  // Power state of the core
  typedef enum logic {
    AWAKE,
    ASLEEP
  } pwr_state_t;

  // All state of the block
  typedef struct packed {
    pwr_state_t                        state;
    logic [POST_W-1:0]                 post_cnt;
    logic                              regulator_sleep_lowpower;
    logic                              sleep_ultralow_select;
    logic                              ultralow_wake_enable;
    logic                              ultralow_wake_sink_enable;
    logic                              soft_watchdog_on;
    logic                              timeout_flag;
    logic                              powerdown_flag;
    logic [wdt_pkg::FREQ_SEL_W-1:0]    freq_sel_prev;
    logic                              freq_sel_seen;
    logic                              osc_en;
    logic                              running;
    logic                              reset_pulse;
    logic                              wake_pulse;
    wdt_pkg::pwr_ctrl_t                pwr;
  } wdt_st_t;

  wdt_st_t s_q, s_d;

  // Bus side
  wdt_pkg::reg_wr_t                wr;
  logic [wdt_pkg::ADDR_W-1:0]      rd_addr;
  logic [wdt_pkg::REG_W-1:0]       rd_data;
  logic [wdt_pkg::REG_W-1:0]       ctrl_rd;
  logic [wdt_pkg::REG_W-1:0]       cause_rd;

  // Watchdog control
  logic                            run;
  logic                            count_clear;
  logic                            freq_change;
  logic                            tick;
  logic                            expire;
  logic [wdt_pkg::SEL_W-1:0]       sel_eff;
  logic [POST_W-1:0]               tap_last;

  // Register port
  ahb_reg_port #(
    .AW (wdt_pkg::ADDR_W)
  ) u_port (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .wr_o        (wr),
    .rd_addr_o   (rd_addr),
    .rd_data_i   (rd_data)
  );

  // Mode decode; software enable only counts when configuration leaves it off
  always_comb begin
    case (cfg_i.watchdog_mode_cfg)
      wdt_pkg::MODE_ALWAYS: begin
        run = 1'b1;
      end
      wdt_pkg::MODE_AWAKE_ONLY: begin
        run = (s_q.state == AWAKE);
      end
      wdt_pkg::MODE_SOFT: begin
        run = s_q.soft_watchdog_on;
      end
      default: begin
        run = s_q.soft_watchdog_on;
      end
    endcase
  end

  // First cycle after reset has no previous select to compare against
  assign freq_change = s_q.freq_sel_seen && (int_osc_freq_select_i != s_q.freq_sel_prev);

  // Every clear source also restarts the base divider
  assign count_clear = clear_watchdog_instr_i || sleep_instr_i
                       || freq_change || clock_fail_i;

  // Base 4 ms tick from the slow oscillator domain model
  base_tick_gen #(
    .CYCLES (BASE_CYCLES)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (run),
    .clear_i (count_clear),
    .tick_o  (tick)
  );

  // Tap select saturates at the longest period
  assign sel_eff  = (cfg_i.post_sel > wdt_pkg::SEL_W'(POST_W)) ? wdt_pkg::SEL_W'(POST_W)
                                                                : cfg_i.post_sel;
  assign tap_last = {POST_W{1'b1}} >> (POST_W - int'(sel_eff));

  // A clear in the expiry cycle wins, so a late clear still saves the core
  assign expire = run && tick && !count_clear && (s_q.post_cnt == tap_last);

  // Next state
  always_comb begin
    s_d             = s_q;
    s_d.reset_pulse = 1'b0;
    s_d.wake_pulse  = 1'b0;

    // Oscillator change tracking
    s_d.freq_sel_prev = int_osc_freq_select_i;
    s_d.freq_sel_seen = 1'b1;

    // Postscaler counts base ticks and resets on any clear
    if (count_clear || !run) begin
      s_d.post_cnt = '0;
    end else if (tick) begin
      if (s_q.post_cnt == tap_last) begin
        s_d.post_cnt = '0;
      end else begin
        s_d.post_cnt = s_q.post_cnt + 1'b1;
      end
    end

    // Software writes to the control register
    if (wr.valid && (wr.addr == wdt_pkg::CTRL_OFS)) begin
      // Bypassed regulator leaves nothing to put into low power
      s_d.regulator_sleep_lowpower = wr.data[wdt_pkg::REG_LOWPOWER_BIT]
                                     && !cfg_i.regulator_bypass;
      if (!cfg_i.regulator_retention_cfg_n) begin
        s_d.sleep_ultralow_select = wr.data[wdt_pkg::SLEEP_ULTRA_BIT];
      end
      s_d.ultralow_wake_enable      = wr.data[wdt_pkg::ULP_ENABLE_BIT];
      s_d.ultralow_wake_sink_enable = wr.data[wdt_pkg::ULP_SINK_BIT];
      s_d.soft_watchdog_on          = wr.data[wdt_pkg::SOFT_ON_BIT];
    end

    // Reset cause flags, write one to clear
    if (wr.valid && (wr.addr == wdt_pkg::RESET_CAUSE_OFS)) begin
      if (wr.data[wdt_pkg::TIMEOUT_FLAG_BIT]) begin
        s_d.timeout_flag = 1'b0;
      end
      if (wr.data[wdt_pkg::POWERDOWN_FLAG_BIT]) begin
        s_d.powerdown_flag = 1'b0;
      end
    end

    // Power state; hardware sets below take priority over the clears
    case (s_q.state)
      AWAKE: begin
        if (expire) begin
          s_d.reset_pulse  = 1'b1;
          s_d.timeout_flag = 1'b1;
        end else if (sleep_instr_i) begin
          s_d.state          = ASLEEP;
          s_d.powerdown_flag = 1'b1;
        end
      end
      ASLEEP: begin
        if (expire) begin
          s_d.wake_pulse   = 1'b1;
          s_d.timeout_flag = 1'b1;
          s_d.state        = AWAKE;
        end else if (wake_event_i) begin
          s_d.state = AWAKE;
        end
      end
      default: begin
        s_d.state = AWAKE;
      end
    endcase

    // Slow oscillator runs for the watchdog or the clock monitor
    s_d.osc_en  = run || cfg_i.fail_safe_clock_monitor;
    s_d.running = run;

    // Regulator selects only matter while asleep
    s_d.pwr.reg_ultralow = (s_d.state == ASLEEP) && s_q.sleep_ultralow_select
                           && !cfg_i.regulator_retention_cfg_n
                           && !cfg_i.regulator_bypass;
    s_d.pwr.reg_lowpower = (s_d.state == ASLEEP) && s_q.regulator_sleep_lowpower
                           && !cfg_i.regulator_bypass
                           && !s_d.pwr.reg_ultralow;
    s_d.pwr.ultralow_wake_enable      = s_q.ultralow_wake_enable;
    s_d.pwr.ultralow_wake_sink_enable = s_q.ultralow_wake_enable
                                        && s_q.ultralow_wake_sink_enable;
  end

  // State register; wake-up bits given a defined zero too
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Control register readback; unimplemented bits stay zero
  always_comb begin
    ctrl_rd                                = '0;
    ctrl_rd[wdt_pkg::REG_LOWPOWER_BIT]     = s_q.regulator_sleep_lowpower;
    ctrl_rd[wdt_pkg::ULP_LEVEL_BIT]        = s_q.ultralow_wake_enable
                                             && ultralow_wake_level_i;
    ctrl_rd[wdt_pkg::SLEEP_ULTRA_BIT]      = s_q.sleep_ultralow_select;
    ctrl_rd[wdt_pkg::ULP_ENABLE_BIT]       = s_q.ultralow_wake_enable;
    ctrl_rd[wdt_pkg::ULP_SINK_BIT]         = s_q.ultralow_wake_sink_enable;
    ctrl_rd[wdt_pkg::SOFT_ON_BIT]          = s_q.soft_watchdog_on;
    cause_rd                               = '0;
    cause_rd[wdt_pkg::TIMEOUT_FLAG_BIT]    = s_q.timeout_flag;
    cause_rd[wdt_pkg::POWERDOWN_FLAG_BIT]  = s_q.powerdown_flag;
    if (rd_addr == wdt_pkg::CTRL_OFS) begin
      rd_data = ctrl_rd;
    end else if (rd_addr == wdt_pkg::RESET_CAUSE_OFS) begin
      rd_data = cause_rd;
    end else begin
      rd_data = '0; // Unmapped reads as zero
    end
  end

  // Outputs, all from flops
  assign low_freq_internal_osc_en_o = s_q.osc_en;
  assign watchdog_running_o         = s_q.running;
  assign watchdog_reset_o           = s_q.reset_pulse;
  assign watchdog_wake_o            = s_q.wake_pulse;
  assign asleep_o                   = (s_q.state == ASLEEP);
  assign pwr_o                      = s_q.pwr;

endmodule // watchdog_with_sleep_control

// [wdt_asserts.sv]
// Concurrent checks on the watchdog top module, seen only through its ports.
// Assumes BASE_CYCLES of at least 2, so no expiry can follow a clear at once.
`timescale 1ns/1ps
module wdt_asserts (
  // Clock and reset
  input wire logic                           clk_i,
  input wire logic                           rst_n_i,
  // Watched inputs
  input wire wdt_pkg::cfg_t                  cfg_i,
  input wire logic [wdt_pkg::FREQ_SEL_W-1:0] int_osc_freq_select_i,
  input wire logic                           clear_watchdog_instr_i,
  input wire logic                           sleep_instr_i,
  input wire logic                           clock_fail_i,
  // Watched outputs
  input wire logic [31:0]                    hrdata_o,
  input wire logic                           hreadyout_o,
  input wire logic                           hresp_o,
  input wire logic                           low_freq_internal_osc_en_o,
  input wire logic                           watchdog_running_o,
  input wire logic                           watchdog_reset_o,
  input wire logic                           watchdog_wake_o,
  input wire logic                           asleep_o,
  input wire wdt_pkg::pwr_ctrl_t             pwr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Two quiet cycles: the restarted divider cannot tick sooner
  sequence s_no_expiry;
    !(watchdog_reset_o || watchdog_wake_o) [*2];
  endsequence

  property p_bus_okay; hreadyout_o && !hresp_o && hrdata_o[31:8] == 24'h0; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not OKAY");
  property p_osc_on; watchdog_running_o |-> low_freq_internal_osc_en_o; endproperty
  a_osc_on: assert property (p_osc_on) else $error("osc off while running");
  property p_fail_safe_clock_monitor_osc;
    $past(rst_n_i) && $past(cfg_i.fail_safe_clock_monitor) |-> low_freq_internal_osc_en_o;
  endproperty
  a_fail_safe_clock_monitor_osc: assert property (p_fail_safe_clock_monitor_osc) else $error("osc off with monitor");
  property p_always_on;
    $past(rst_n_i) && $past(cfg_i.watchdog_mode_cfg) == wdt_pkg::MODE_ALWAYS |-> watchdog_running_o;
  endproperty
  a_always_on: assert property (p_always_on) else $error("stopped in always mode");
  property p_clear_quiet;
    clear_watchdog_instr_i || sleep_instr_i || clock_fail_i |=> s_no_expiry;
  endproperty
  a_clear_quiet: assert property (p_clear_quiet) else $error("expiry after clear");
  property p_freq_quiet; $changed(int_osc_freq_select_i) |=> s_no_expiry; endproperty
  a_freq_quiet: assert property (p_freq_quiet) else $error("expiry after freq change");
  property p_reset_pulse; watchdog_reset_o |-> !watchdog_wake_o && !$past(asleep_o) ##1 !watchdog_reset_o; endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("bad reset pulse");
  property p_wake_pulse; watchdog_wake_o |-> $past(asleep_o) ##1 !asleep_o && !watchdog_wake_o; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("bad wake pulse");
  property p_bypass_lp; $past(rst_n_i) && $past(cfg_i.regulator_bypass) |-> !pwr_o.reg_lowpower; endproperty
  a_bypass_lp: assert property (p_bypass_lp) else $error("low power in bypass");
  property p_sink_gated; pwr_o.ultralow_wake_sink_enable |-> pwr_o.ultralow_wake_enable; endproperty
  a_sink_gated: assert property (p_sink_gated) else $error("sink without wake module");
  property p_ultra_ret; pwr_o.reg_ultralow |-> !$past(cfg_i.regulator_retention_cfg_n); endproperty
  a_ultra_ret: assert property (p_ultra_ret) else $error("ultra-low without retention");
endmodule // wdt_asserts

bind watchdog_with_sleep_control wdt_asserts u_chk (
  .clk_i, .rst_n_i, .cfg_i, .int_osc_freq_select_i, .clear_watchdog_instr_i, .sleep_instr_i, .clock_fail_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .low_freq_internal_osc_en_o, .watchdog_running_o, .watchdog_reset_o,
  .watchdog_wake_o, .asleep_o, .pwr_o);

// [testbench.sv]
// Self-checking bench for the watchdog with sleep control.
// Assumes the bound checker; base divider shortened to 4 clocks.
`timescale 1ns/1ps
`define CMP(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module testbench;
  localparam int unsigned BASE  = 4;
  localparam logic [11:0] CTRL  = wdt_pkg::CTRL_OFS;
  localparam logic [11:0] CAUSE = wdt_pkg::RESET_CAUSE_OFS;
  typedef struct {
    string       nm;
    logic [31:0] e;
    int          due;
  } note_t;
  // Stimulus
  logic               clk_i   = 1'b0;
  logic               rst_n_i = 1'b0;
  logic               hsel    = 1'b0;
  logic               hwrite  = 1'b0;
  logic [1:0]         htrans  = 2'h0;
  logic [2:0]         hsize   = 3'h0;
  logic [31:0]        haddr   = 32'h0;
  logic [31:0]        hwdata  = 32'h0;
  logic [3:0]         evt     = 4'h0;
  logic [2:0]         freq    = 3'h0;
  logic               lvl     = 1'b1;
  wdt_pkg::cfg_t      cfg     = '0;
  // Design outputs
  logic [31:0]        hrdata;
  logic               hready, hresp, osc_en, running, wd_rst, wd_wake, asleep;
  wdt_pkg::pwr_ctrl_t pwr;
  // Notes and counters
  note_t              notes[$];
  note_t              cur;
  logic [31:0]        lfsr_q = 32'hb168;
  logic [31:0]        snap;
  int                 err_total, n_compared, cyc, rst_cnt, wake_cnt, gap, since;

  always #20 clk_i = ~clk_i;

  watchdog_with_sleep_control #(.BASE_CYCLES(BASE)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .cfg_i(cfg), .int_osc_freq_select_i(freq), .clear_watchdog_instr_i(evt[0]),
    .sleep_instr_i(evt[1]), .wake_event_i(evt[2]), .clock_fail_i(evt[3]), .ultralow_wake_level_i(lvl),
    .low_freq_internal_osc_en_o(osc_en), .watchdog_running_o(running), .watchdog_reset_o(wd_rst),
    .watchdog_wake_o(wd_wake), .asleep_o(asleep), .pwr_o(pwr));

  // Retire due notes; NBA counters avoid races
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    since <= evt[0] ? 0 : since + 1;
    if (wd_rst === 1'b1) rst_cnt <= rst_cnt + 1;
    if (wd_wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (wd_rst === 1'b1 || wd_wake === 1'b1) gap <= since;
    while (notes.size() > 0 && notes[0].due == cyc) begin
      cur = notes.pop_front();
      case (cur.nm)
        "rd":    `CMP(cur.nm, cur.e, hrdata)
        "run":   `CMP(cur.nm, cur.e[1:0], {osc_en, running})
        "slp":   `CMP(cur.nm, cur.e[0], asleep)
        "ulp":   `CMP(cur.nm, cur.e[1:0], {pwr.ultralow_wake_enable, pwr.ultralow_wake_sink_enable})
        "cnt":   `CMP(cur.nm, cur.e, {rst_cnt[15:0], wake_cnt[15:0]})
        default: `CMP(cur.nm, 1'b1, gap >= cur.e && gap <= cur.e + 5)
      endcase
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Note, checked next edge
  task automatic note(input string nm, input logic [31:0] e);
    notes.push_back('{nm, e, cyc + 1});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask

  // Bounded wait for hready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin err_total++; finish_test(); end
  endtask

  // Single word transfer; a read notes d
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= wdt_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= wr;
    hsize <= wdt_pkg::HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    if (!wr) note("rd", d);
    wait_rdy();
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    bus(1'b0, a, {24'h0, d});
  endtask

  // Pulse event k, then a spare edge
  task automatic ev(input int k);
    evt <= 4'h1 << k;
    @(posedge clk_i);
    evt <= 4'h0;
    @(posedge clk_i);
  endtask

  // Bounded wait for an expiry
  task automatic wait_exp();
    int c0, n;
    c0 = rst_cnt + wake_cnt;
    n = 0;
    while (rst_cnt + wake_cnt == c0 && n < 200) begin @(posedge clk_i); n++; end
    if (n >= 200) begin err_total++; finish_test(); end
  endtask

  // Main sequence
  initial begin
    cycles(6);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(CTRL, 8'h00);
    rd(CAUSE, 8'h00);
    rd(12'h010, 8'h00);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      bus(1'b1, CTRL, lfsr_q);
      rd(CTRL, lfsr_q[7:0] & 8'h97 | {2'h0, lfsr_q[2], 5'h0});
      note("ulp", {lfsr_q[2], lfsr_q[2] & lfsr_q[1]});
      cycles(2);
      note("run", {2{lfsr_q[0]}});
    end
    done("random control");
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        cfg.watchdog_mode_cfg <= 2'(m);
        wr(CTRL, 8'(s));
        cycles(2);
        note("run", {2{2'(m) >= wdt_pkg::MODE_AWAKE_ONLY || s == 1}});
      end
    end
    cfg.fail_safe_clock_monitor <= 1'b1;
    cfg.watchdog_mode_cfg <= wdt_pkg::MODE_OFF;
    wr(CTRL, 8'h00);
    cycles(2);
    note("run", 32'h2);
    cfg.fail_safe_clock_monitor <= 1'b0;
    done("modes");
    cfg.watchdog_mode_cfg <= wdt_pkg::MODE_ALWAYS;
    for (int sel = 0; sel < 4; sel++) begin
      cfg.post_sel <= 5'(sel);
      ev(0);
      wait_exp();
      note("gap", (BASE << sel) - 1);
    end
    cfg.watchdog_mode_cfg <= wdt_pkg::MODE_OFF;
    cycles(3);
    rd(CAUSE, 8'h08);
    wr(CAUSE, 8'h08);
    rd(CAUSE, 8'h00);
    done("periods");
    cfg.watchdog_mode_cfg <= wdt_pkg::MODE_ALWAYS;
    cfg.post_sel <= 5'd2;
    ev(0);
    cycles(2);
    snap = {rst_cnt[15:0], wake_cnt[15:0]};
    for (int i = 0; i < 9; i++) begin
      if (i % 3 == 1) freq <= freq + 3'h1;
      else ev(i % 3 == 0 ? 0 : 3);
      cycles(10);
    end
    note("cnt", snap);
    wait_exp();
    note("cnt", snap + 32'h10000);
    ev(0);
    cycles(2);
    snap = {rst_cnt[15:0], wake_cnt[15:0]};
    ev(1);
    note("slp", 32'h1);
    wait_exp();
    note("cnt", snap + 32'h1);
    cycles(1);
    note("slp", 32'h0);
    cfg.watchdog_mode_cfg <= wdt_pkg::MODE_AWAKE_ONLY;
    ev(1);
    cycles(1);
    note("run", 32'h0);
    ev(2);
    cycles(1);
    note("run", 32'h3);
    cfg.watchdog_mode_cfg <= wdt_pkg::MODE_OFF;
    rd(CAUSE, 8'h0c);
    done("clears and sleep");
    cfg.regulator_bypass <= 1'b1;
    wr(CTRL, 8'h80);
    rd(CTRL, 8'h00);
    cfg.regulator_bypass <= 1'b0;
    cfg.regulator_retention_cfg_n <= 1'b1;
    wr(CTRL, 8'h90);
    rd(CTRL, 8'h80);
    cfg.regulator_retention_cfg_n <= 1'b0;
    wr(CTRL, 8'h10);
    rd(CTRL, 8'h10);
    wr(CTRL, 8'h02);
    rd(CTRL, 8'h02);
    note("ulp", 32'h0);
    lvl <= 1'b0;
    wr(CTRL, 8'h06);
    rd(CTRL, 8'h06);
    lvl <= 1'b1;
    rd(CTRL, 8'h26);
    note("ulp", 32'h3);
    done("regulator");
    cycles(2);
    finish_test();
  end
endmodule // testbench
